/* gbcd_defs.vh */
`ifndef GBCD_DEFS_VH
`define GBCD_DEFS_VH

// ----------------------------------------------------------------
// multiline command codes (7-bit, taken with attention true)
// ----------------------------------------------------------------
`define GBCD_CMD_GO_LOCAL 7'h01
`define GBCD_CMD_SEL_CLEAR 7'h04
`define GBCD_CMD_TRIGGER 7'h08
`define GBCD_CMD_LOCKOUT 7'h11
`define GBCD_CMD_DEV_CLEAR 7'h14
`define GBCD_CMD_POLL_ON 7'h18
`define GBCD_CMD_POLL_OFF 7'h19
`define GBCD_CMD_UNLISTEN 7'h3f
`define GBCD_CMD_UNTALK 7'h5f

// ----------------------------------------------------------------
// address groups: top two bits of the 7-bit byte
// ----------------------------------------------------------------
`define GBCD_GRP_LISTEN 2'h1
`define GBCD_GRP_TALK 2'h2
`define GBCD_GRP_SECOND 2'h3
`define GBCD_GRP_MSB 6
`define GBCD_GRP_LSB 5

// ----------------------------------------------------------------
// pin vector layout after the synchroniser
// ----------------------------------------------------------------
`define GBCD_PIN_W 13
`define GBCD_PIN_DIO_MSB 7
`define GBCD_PIN_DAV 8
`define GBCD_PIN_EOI 9
`define GBCD_PIN_REN 10
`define GBCD_PIN_IFC 11
`define GBCD_PIN_ATN 12
`define GBCD_PIN_IDLE 13'h1fff

// ----------------------------------------------------------------
// timing: bus lines settle this many cycles after the strobe
// ----------------------------------------------------------------
`define GBCD_SETTLE_CYC 2'h2

`endif

/* gbcd_buf2.v */
`timescale 1ns/1ps

// two-entry buffer: an output register plus one skid register, so
// both sides see registered handshakes and a stall loses nothing
module gbcd_buf2 #(
  parameter W = 9
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset,
  // filling side
  input wire i_valid,
  input wire [W-1:0] i_data,
  output wire o_ready,
  // draining side
  output wire o_valid,
  output wire [W-1:0] o_data,
  input wire i_ready
);

  reg out_v_r;
  reg [W-1:0] out_d_r;
  reg sk_v_r;
  reg [W-1:0] sk_d_r;
  wire push;
  wire pop;

  // full only when the skid slot is taken
  assign o_ready = ~sk_v_r;
  assign o_valid = out_v_r;
  assign o_data = out_d_r;
  assign push = i_valid & ~sk_v_r;
  assign pop = out_v_r & i_ready;

  // move words forward, skid first to keep order
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      out_v_r <= 1'b0;
      out_d_r <= {W{1'b0}};
      sk_v_r <= 1'b0;
      sk_d_r <= {W{1'b0}};
    end else if (pop) begin
      if (sk_v_r) begin
        out_d_r <= sk_d_r;
        sk_v_r <= 1'b0;
      end else if (push) begin
        out_d_r <= i_data;
      end else begin
        out_v_r <= 1'b0;
      end
    end else if (push) begin
      if (!out_v_r) begin
        out_v_r <= 1'b1;
        out_d_r <= i_data;
      end else begin
        sk_v_r <= 1'b1;
        sk_d_r <= i_data;
      end
    end
  end

endmodule // gbcd_buf2

/* gbcd_decoder.v */
`timescale 1ns/1ps
`include "gbcd_defs.vh"

module gbcd_decoder #(
  parameter DW = 8
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset,
  // bus lines, active low, asynchronous to the clock
  input wire i_atn_n,
  input wire i_ifc_n,
  input wire i_ren_n,
  input wire i_eoi_n,
  input wire i_dav_n,
  input wire [DW-1:0] i_dio_n,
  // acceptor handshake lines, open drain
  input wire i_nrfd_n,
  output reg o_nrfd_n,
  output reg o_nrfd_oe,
  input wire i_ndac_n,
  output reg o_ndac_n,
  output reg o_ndac_oe,
  // service request line, open drain
  input wire i_srq_n,
  output reg o_srq_n,
  output reg o_srq_oe,
  // instrument configuration and front panel
  input wire [4:0] i_pri_addr,
  input wire i_service_req,
  input wire i_local_key,
  // interface state
  output reg o_listener,
  output reg o_talker,
  output reg o_remote,
  output reg o_lockout,
  output reg o_spoll,
  // one-cycle events to the instrument
  output reg o_dev_clear,
  output reg o_trigger,
  // data bytes to the instrument
  output wire [DW-1:0] o_data,
  output wire o_data_eoi,
  output wire o_data_valid,
  input wire i_data_ready
);

  // ----------------------------------------------------------------
  // acceptor states
  // ----------------------------------------------------------------
  localparam ST_READY = 4'b0001;
  localparam ST_SETTLE = 4'b0010;
  localparam ST_TAKE = 4'b0100;
  localparam ST_DONE = 4'b1000;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  reg [`GBCD_PIN_W-1:0] pin_s1_r;
  reg [`GBCD_PIN_W-1:0] pin_s2_r;

  // first stage is read by the second stage only
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      pin_s1_r <= `GBCD_PIN_IDLE;
      pin_s2_r <= `GBCD_PIN_IDLE;
    end else begin
      pin_s1_r <= {i_atn_n, i_ifc_n, i_ren_n, i_eoi_n, i_dav_n, i_dio_n};
      pin_s2_r <= pin_s1_r;
    end
  end

  // low level is the true state on every line
  wire atn_t = ~pin_s2_r[`GBCD_PIN_ATN];
  wire ifc_t = ~pin_s2_r[`GBCD_PIN_IFC];
  wire ren_t = ~pin_s2_r[`GBCD_PIN_REN];
  wire eoi_t = ~pin_s2_r[`GBCD_PIN_EOI];
  wire dav_t = ~pin_s2_r[`GBCD_PIN_DAV];
  wire [DW-1:0] byte_t = ~pin_s2_r[`GBCD_PIN_DIO_MSB:0];
  wire [6:0] cmd = byte_t[6:0];
  wire [1:0] grp = cmd[`GBCD_GRP_MSB:`GBCD_GRP_LSB];

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  reg [3:0] st_r;
  reg [3:0] st_nxt;
  reg [1:0] settle_r;
  reg ren_d_r;
  reg listener_nxt;
  reg talker_nxt;
  reg remote_nxt;
  reg lockout_nxt;
  reg spoll_nxt;
  reg dev_clear_nxt;
  reg trigger_nxt;
  reg push;
  wire buf_ready;
  wire take = (st_r == ST_TAKE);
  wire take_cmd = take & atn_t;

  // a listener or any byte under attention joins the handshake
  wire engaged = atn_t | o_listener;

  // ----------------------------------------------------------------
  // acceptor sequence
  // ----------------------------------------------------------------
  // data lines may trail the strobe, so wait a few cycles before use
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_READY: begin
        if (dav_t && engaged && buf_ready) begin
          st_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_r == `GBCD_SETTLE_CYC) begin
          st_nxt = ST_TAKE;
        end
      end
      ST_TAKE: begin
        st_nxt = ST_DONE;
      end
      ST_DONE: begin
        if (!dav_t) begin
          st_nxt = ST_READY;
        end
      end
      default: begin
        st_nxt = ST_READY;
      end
    endcase
  end

  // settle counter and state
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_r <= ST_READY;
      settle_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_SETTLE) begin
        settle_r <= settle_r + 2'h1;
      end else begin
        settle_r <= 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // later branches win, so unlisten beats a matching listen address
  always @* begin
    listener_nxt = o_listener;
    talker_nxt = o_talker;
    remote_nxt = o_remote;
    lockout_nxt = o_lockout;
    spoll_nxt = o_spoll;
    dev_clear_nxt = 1'b0;
    trigger_nxt = 1'b0;
    push = 1'b0;
    // remote follows the edge of remote enable so go-to-local sticks
    if (ren_t && !ren_d_r) begin
      remote_nxt = 1'b1;
    end
    if (take_cmd) begin
      case (cmd)
        `GBCD_CMD_LOCKOUT: lockout_nxt = 1'b1;
        `GBCD_CMD_DEV_CLEAR: dev_clear_nxt = 1'b1;
        `GBCD_CMD_POLL_ON: spoll_nxt = 1'b1;
        `GBCD_CMD_POLL_OFF: spoll_nxt = 1'b0;
        default: begin
        end
      endcase
      if (o_listener) begin
        case (cmd)
          `GBCD_CMD_SEL_CLEAR: dev_clear_nxt = 1'b1;
          `GBCD_CMD_GO_LOCAL: begin
            remote_nxt = 1'b0;
            lockout_nxt = 1'b0;
          end
          `GBCD_CMD_TRIGGER: trigger_nxt = 1'b1;
          default: begin
          end
        endcase
      end
      case (grp)
        `GBCD_GRP_LISTEN: begin
          if (cmd[4:0] == i_pri_addr) begin
            listener_nxt = 1'b1;
          end
          if (cmd == `GBCD_CMD_UNLISTEN) begin
            listener_nxt = 1'b0;
          end
        end
        `GBCD_GRP_TALK: begin
          // another device's talk address also makes us talker idle
          talker_nxt = (cmd[4:0] == i_pri_addr);
          if (cmd == `GBCD_CMD_UNTALK) begin
            talker_nxt = 1'b0;
          end
        end
        `GBCD_GRP_SECOND: begin
          // no secondary addressing here
          talker_nxt = o_talker;
        end
        default: begin
        end
      endcase
    end
    // data bytes go to the instrument when listening
    if (take && !atn_t && o_listener) begin
      push = 1'b1;
    end
    // front panel local key, honoured unless locked out
    if (i_local_key && !lockout_nxt) begin
      remote_nxt = 1'b0;
    end
    // lockout and remote both fall with remote enable
    if (!ren_t) begin
      remote_nxt = 1'b0;
      lockout_nxt = 1'b0;
    end
    // interface clear overrides the listener, talker and poll state this byte set
    if (ifc_t) begin
      listener_nxt = 1'b0;
      talker_nxt = 1'b0;
      spoll_nxt = 1'b0;
    end
  end

  // interface state registers
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      ren_d_r <= 1'b0;
      o_listener <= 1'b0;
      o_talker <= 1'b0;
      o_remote <= 1'b0;
      o_lockout <= 1'b0;
      o_spoll <= 1'b0;
      o_dev_clear <= 1'b0;
      o_trigger <= 1'b0;
    end else begin
      ren_d_r <= ren_t;
      o_listener <= listener_nxt;
      o_talker <= talker_nxt;
      o_remote <= remote_nxt;
      o_lockout <= lockout_nxt;
      o_spoll <= spoll_nxt;
      o_dev_clear <= dev_clear_nxt;
      o_trigger <= trigger_nxt;
    end
  end

  // ----------------------------------------------------------------
  // open-drain line drivers
  // ----------------------------------------------------------------
  // the device never drives attention, clear or remote; only these
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_nrfd_n <= 1'b0;
      o_nrfd_oe <= 1'b0;
      o_ndac_n <= 1'b0;
      o_ndac_oe <= 1'b0;
      o_srq_n <= 1'b0;
      o_srq_oe <= 1'b0;
    end else begin
      // hold not-ready unless idle and the buffer can take a byte
      o_nrfd_oe <= engaged & ~(st_nxt == ST_READY & buf_ready);
      // release not-accepted once the byte has been taken
      o_ndac_oe <= engaged & (st_nxt != ST_DONE);
      o_srq_oe <= i_service_req;
    end
  end

  // ----------------------------------------------------------------
  // data buffer
  // ----------------------------------------------------------------
  // the end flag rides with its byte so the receiver sees message end
  gbcd_buf2 #(
    .W(DW + 1)
  ) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_valid(push),
    .i_data({eoi_t, byte_t}),
    .o_ready(buf_ready),
    .o_valid(o_data_valid),
    .o_data({o_data_eoi, o_data}),
    .i_ready(i_data_ready)
  );

endmodule // gbcd_decoder

/* gbcd_properties.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// pin checks: effects land 4..7 edges after dav falls (sync)
// ------------------------------------------------------------
module gbcd_checker #(
  parameter DW = 8
) (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_atn_n,
  input wire i_ifc_n,
  input wire i_ren_n,
  input wire i_dav_n,
  input wire [DW-1:0] i_dio_n,
  input wire [4:0] i_pri_addr,
  input wire i_service_req,
  input wire i_data_ready,
  input wire o_nrfd_oe,
  input wire o_srq_n,
  input wire o_srq_oe,
  input wire o_listener,
  input wire o_talker,
  input wire o_remote,
  input wire o_lockout,
  input wire o_spoll,
  input wire o_dev_clear,
  input wire o_trigger,
  input wire [DW-1:0] o_data,
  input wire o_data_eoi,
  input wire o_data_valid
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // byte strobed with attention true and no interface clear
  sequence s_cmd(logic [6:0] c);
    $fell(i_dav_n) && !i_atn_n && i_ifc_n && (~i_dio_n[6:0] == c);
  endsequence
  // clear held long enough to pass the synchroniser
  sequence s_ifc;
    !i_ifc_n [*4];
  endsequence
  a_lockout_set: assert property (s_cmd(7'h11) ##0 !i_ren_n |-> ##[4:7] o_lockout)
    else $error("lockout not set");
  a_poll_enter: assert property (s_cmd(7'h18) |-> ##[4:7] o_spoll)
    else $error("poll mode not entered");
  a_clear_pulse: assert property (s_cmd(7'h14) |-> ##[4:7] o_dev_clear ##1 !o_dev_clear)
    else $error("device clear pulse wrong");
  a_listen_own: assert property (s_cmd({2'h1, i_pri_addr}) ##0 i_pri_addr != 5'h1f |-> ##[4:7] o_listener)
    else $error("own listen address ignored");
  a_talk_own: assert property (s_cmd({2'h2, i_pri_addr}) |-> ##[4:7] o_talker)
    else $error("own talk address ignored");
  a_unlisten_idle: assert property (s_cmd(7'h3f) |-> ##[4:7] !o_listener)
    else $error("unlisten ignored");
  a_ifc_idle: assert property (s_ifc |=> !o_listener && !o_talker && !o_spoll)
    else $error("interface clear ignored");
  a_remote_on: assert property ($fell(i_ren_n) ##0 i_ifc_n |-> ##[1:4] o_remote)
    else $error("remote not entered");
  a_srq_follow: assert property (i_service_req |=> o_srq_oe && !o_srq_n)
    else $error("service request not driven");
  a_trig_listen: assert property (o_trigger |-> o_listener)
    else $error("trigger while not listener");
  a_nrfd_on_dav: assert property ($rose(o_nrfd_oe) |-> !$past(i_dav_n))
    else $error("not ready raised without strobe");
  a_word_stands: assert property (o_data_valid && !i_data_ready |=> o_data_valid && $stable({o_data_eoi, o_data}))
    else $error("held word changed");
endmodule // gbcd_checker

bind gbcd_decoder gbcd_checker #(.DW(DW)) gbcd_checker_i (
  .i_ref_clk, .i_reset, .i_atn_n, .i_ifc_n, .i_ren_n, .i_dav_n, .i_dio_n,
  .i_pri_addr, .i_service_req, .i_data_ready, .o_nrfd_oe, .o_srq_n,
  .o_srq_oe, .o_listener, .o_talker, .o_remote, .o_lockout, .o_spoll,
  .o_dev_clear, .o_trigger, .o_data, .o_data_eoi, .o_data_valid
);

/* gbcd_ctrl_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus controller: sources bytes, released lines float high
// ------------------------------------------------------------
module gbcd_ctrl_model (
  // acceptor wire levels
  input wire i_ref_clk,
  input wire i_nrfd_n,
  input wire i_ndac_n,
  // controller lines, low true
  output logic o_atn_n = 1'b1,
  output logic o_ifc_n = 1'b1,
  output logic o_ren_n = 1'b1,
  output logic o_eoi_n = 1'b1,
  output logic o_dav_n = 1'b1,
  output logic [7:0] o_dio_n = 8'hff
);
  // uniline commands; only this side drives them
  task automatic lines(input logic ren, input logic ifc);
    @(posedge i_ref_clk) #1;
    o_ren_n = ~ren;
    o_ifc_n = ~ifc;
    repeat (4) @(posedge i_ref_clk);
  endtask
  // one byte; acc says an acceptor should answer
  task automatic send(input logic atn, input logic [7:0] b,
                      input logic eoi, input logic acc, output logic ok);
    int n;
    n = 0;
    @(posedge i_ref_clk) #1;
    o_atn_n = ~atn;
    o_dio_n = ~b;
    o_eoi_n = ~eoi;
    repeat (4) @(posedge i_ref_clk);
    // ready and previous byte not accepted before strobing
    while (acc && (i_nrfd_n !== 1'b1 || i_ndac_n !== 1'b0) && n < 200) begin
      @(posedge i_ref_clk);
      n++;
    end
    #1;
    o_dav_n = 1'b0;
    repeat (8) @(posedge i_ref_clk);
    while (acc && i_ndac_n !== 1'b1 && n < 200) begin
      @(posedge i_ref_clk);
      n++;
    end
    #1;
    o_dav_n = 1'b1;
    o_dio_n = 8'hff;
    o_eoi_n = 1'b1;
    repeat (6) @(posedge i_ref_clk);
    ok = (n < 200);
  endtask
endmodule // gbcd_ctrl_model

/* tb_gpib_bus_command_decoder.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// decoder bench: command table, then data path and uniline
// ------------------------------------------------------------
module tb_gpib_bus_command_decoder;
  logic i_ref_clk = 0;
  logic i_reset = 1;
  logic [4:0] i_pri_addr = 5'h16;
  logic i_service_req = 0;
  logic i_local_key = 0;
  logic i_data_ready = 0;
  wire atn_n, ifc_n, ren_n, eoi_n, dav_n;
  wire [7:0] dio_n;
  wire [7:0] data;
  wire nrfd_oe, ndac_oe, srq_oe, data_eoi, data_valid;
  wire listener, talker, remote, lockout, spoll, dev_clear, trigger;
  int error_cnt = 0;
  int compares = 0;
  int n_clr = 0;
  int n_trg = 0;
  int c0, t0;
  // {atn, byte, listener talker remote lockout poll, clear, trigger}
  logic [15:0] rows [17] = '{16'h9f90, 16'h8a12, 16'h8210, 16'h8410,
    16'h8898, 16'h8098, 16'h8c1c, 16'h9b5c, 16'hab7c, 16'hbafc,
    16'h9bfc, 16'h827e, 16'h847d, 16'h8cf8, 16'hafd8, 16'h80c0,
    16'h9f80};
  logic [8:0] words [3] = '{9'h052, 9'h030, 9'h158};

  gbcd_decoder #(.DW(8)) gbcd_decoder_i (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_atn_n(atn_n),
    .i_ifc_n(ifc_n), .i_ren_n(ren_n), .i_eoi_n(eoi_n), .i_dav_n(dav_n),
    .i_dio_n(dio_n), .i_nrfd_n(~nrfd_oe), .o_nrfd_n(),
    .o_nrfd_oe(nrfd_oe), .i_ndac_n(~ndac_oe), .o_ndac_n(),
    .o_ndac_oe(ndac_oe), .i_srq_n(~srq_oe), .o_srq_n(), .o_srq_oe(srq_oe),
    .i_pri_addr(i_pri_addr), .i_service_req(i_service_req),
    .i_local_key(i_local_key), .o_listener(listener), .o_talker(talker),
    .o_remote(remote), .o_lockout(lockout), .o_spoll(spoll),
    .o_dev_clear(dev_clear), .o_trigger(trigger), .o_data(data),
    .o_data_eoi(data_eoi), .o_data_valid(data_valid),
    .i_data_ready(i_data_ready));

  gbcd_ctrl_model gbcd_ctrl_model_i (
    .i_ref_clk(i_ref_clk), .i_nrfd_n(~nrfd_oe), .i_ndac_n(~ndac_oe),
    .o_atn_n(atn_n), .o_ifc_n(ifc_n), .o_ren_n(ren_n), .o_eoi_n(eoi_n),
    .o_dav_n(dav_n), .o_dio_n(dio_n));

  // clock and pulse counters
  initial forever #2 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    if (dev_clear === 1'b1) n_clr <= n_clr + 1;
    if (trigger === 1'b1) n_trg <= n_trg + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // a handshake that hangs counts as a mismatch and ends the run
  task automatic put(input logic atn, input logic [7:0] b,
                     input logic eoi, input logic acc);
    logic ok;
    gbcd_ctrl_model_i.send(atn, b, eoi, acc, ok);
    if (!ok) begin
      error_cnt++;
      end_of_test;
    end
  endtask

  // waits for a word, compares it, takes it for one cycle
  task automatic take(input logic [8:0] e);
    int n;
    n = 0;
    while (data_valid !== 1'b1 && n < 100) begin
      wt(1);
      n++;
    end
    check({data_eoi, data}, e);
    i_data_ready = 1;
    wt(1);
    i_data_ready = 0;
  endtask

  // main sequence
  initial begin
    wt(8);
    i_reset = 0;
    wt(3);
    check({listener, talker, remote, lockout, spoll, dev_clear}, 0);
    gbcd_ctrl_model_i.lines(1, 0);
    foreach (rows[k]) begin
      c0 = n_clr;
      t0 = n_trg;
      put(rows[k][15], rows[k][14:7], 1'b0, 1'b1);
      check({listener, talker, remote, lockout, spoll, n_clr - c0 == 1,
             n_trg - t0 == 1}, rows[k][6:0]);
    end
    // two words fill the buffer, the third waits on not-ready
    put(1, 8'h36, 0, 1);
    put(0, 8'h52, 0, 1);
    put(0, 8'h30, 0, 1);
    fork
      put(0, 8'h58, 1, 1);
      begin
        wt(30);
        check(nrfd_oe, 1);
        foreach (words[j]) take(words[j]);
      end
    join
    // data while unaddressed is not accepted
    put(1, 8'h3f, 0, 1);
    put(0, 8'h41, 1, 0);
    check({data_valid, nrfd_oe, ndac_oe}, 0);
    // interface clear drops addressing and poll mode
    put(1, 8'h36, 0, 1);
    put(1, 8'h56, 0, 1);
    put(1, 8'h18, 0, 1);
    gbcd_ctrl_model_i.lines(1, 1);
    check({listener, talker, spoll}, 0);
    gbcd_ctrl_model_i.lines(1, 0);
    // local key leaves remote unless locked out
    for (int k = 0; k < 2; k++) begin
      gbcd_ctrl_model_i.lines(0, 0);
      gbcd_ctrl_model_i.lines(1, 0);
      if (k == 1) put(1, 8'h11, 0, 1);
      check({remote, lockout}, {1'b1, k[0]});
      i_local_key = 1;
      wt(6);
      i_local_key = 0;
      check(remote, k[0]);
    end
    i_service_req = 1;
    wt(2);
    check(srq_oe, 1);
    // address boundaries 0 and 31
    i_pri_addr = 5'h00;
    put(1, 8'h20, 0, 1);
    put(1, 8'h40, 0, 1);
    check({listener, talker}, 3);
    i_pri_addr = 5'h1f;
    put(1, 8'h3f, 0, 1);
    check(listener, 0);
    end_of_test;
  end
endmodule // tb_gpib_bus_command_decoder
